// >>> rtl/trc_pkg.sv
/*
   Shared constants and types for the retimer control block.
   Assumes a 250 MHz system clock; the link clock is the buffered input clock lane.
*/
// Summary of operation
// - While enable is low, controls are ignored and all lanes are high impedance.
// - Low enable clears register settings; strap pins are sampled again at its rise.
// - Recovery circuit is active within 15 ms of retimer operation starting.
// - Recovery circuit turns off within 120 ns of retimer operation ending.
// - Lane swap routes data2 to clock, clock to data2, data1 and data0 crossed.
// - Swap remaps inputs only; equalizer settings follow the new lane position.
// - Lane swap works in both redriver and retimer operation.
// - Swap/polarity pin high inverts every lane, in retimer operation only.
// - In automatic mode polarity inversion is lost at redriver data rates.
// - Equalizer pin high gives 10 dB, low 7.5 dB, floating adaptive.
// - Adaptive equalizer gain follows the detected data rate.
// - With detection on, data terminations connect only after a valid clock.
// - With detection on and no clock: standby, recovery off, lanes high impedance.
// - Detection enabled by strap or register, and disabled after reset.
// - Audio return output is on after initialisation, disabled by register.
// - Termination pin high disables, low reserved, floating selects automatic.
// - Automatic termination: none below 2 Gbps, near-end termination 2 to 3.4 Gbps.
// - Error checker counts errors separately on each of three data lanes.
// - Register enabled pseudo-random generator drives data lanes at input clock rate.
// - Automatic mode acts as redriver below 1 Gbps and as retimer above.
package trc_pkg;
   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_MHZ = 250;
   localparam int CDR_ACQ_US = 7000;
   localparam int CDR_ACQ_CYC = CDR_ACQ_US * CLK_MHZ;
   localparam int CDR_MAX_MS = 15;
   localparam int CDR_MAX_CYC = CDR_MAX_MS * 1000 * CLK_MHZ;
   localparam int CDR_OFF_NS = 120;
   localparam int CDR_OFF_CYC = CDR_OFF_NS * CLK_MHZ / 1000;
   localparam int ACQ_W = 22;
   // ----------------------------------------------------------------
   // Rate measurement: toggle edges of the halved link clock per window
   // ----------------------------------------------------------------
   localparam int RATE_WIN = 256;
   localparam int PIX_MIN_MHZ = 25;
   localparam int PIX_1G_MHZ = 100;
   localparam int PIX_2G_MHZ = 200;
   localparam int CNT_W = 10;
   localparam logic [CNT_W-1:0] CNT_VALID = CNT_W'(PIX_MIN_MHZ * RATE_WIN / CLK_MHZ);
   localparam logic [CNT_W-1:0] CNT_1G = CNT_W'(PIX_1G_MHZ * RATE_WIN / CLK_MHZ);
   localparam logic [CNT_W-1:0] CNT_2G = CNT_W'(PIX_2G_MHZ * RATE_WIN / CLK_MHZ);
   // ----------------------------------------------------------------
   // Modes and codes
   // ----------------------------------------------------------------
   localparam logic [1:0] MODE_REDRV = 2'h0;
   localparam logic [1:0] MODE_RETIME = 2'h1;
   localparam logic [1:0] MODE_AUTO = 2'h2;
   localparam logic [1:0] TRI_LO = 2'h0;
   localparam logic [1:0] TRI_HI = 2'h1;
   localparam logic [1:0] TRI_Z = 2'h2;
   // Equalizer gain in half-dB steps.
   localparam int EQ_W = 5;
   localparam logic [EQ_W-1:0] EQ_10DB = 5'h14;
   localparam logic [EQ_W-1:0] EQ_7P5DB = 5'h0f;
   localparam logic [EQ_W-1:0] EQ_AD_LO = 5'h08;
   localparam logic [EQ_W-1:0] EQ_AD_MID = 5'h0e;
   localparam logic [EQ_W-1:0] EQ_AD_HI = 5'h18;
   localparam int ERR_W = 16;
   localparam int LANES = 4;
   localparam int PRBS_W = 7;
   localparam logic [PRBS_W-1:0] PRBS_SEED = 7'h7f;

   typedef enum logic [2:0] {
      CDR_OFF = 3'b001,
      CDR_ACQ = 3'b010,
      CDR_ON = 3'b100
   } trc_cdr_t;
endpackage

// >>> rtl/trc_sync.sv
/*
   Two flip-flop level synchroniser, any width.
   Assumes each bit is an independent level or toggle.
*/
`timescale 1ns/1ps
module trc_sync #(
   parameter int W = 1
) (
   input wire logic clk_in,
   input wire logic [W-1:0] d_in,
   output logic [W-1:0] q_out
);
   logic [W-1:0] meta_q;

   // The first stage is read only by the second stage.
   always_ff @(posedge clk_in) begin
      meta_q <= d_in;
      q_out <= meta_q;
   end
endmodule // trc_sync

// >>> rtl/trc_ctrl.sv
/*
   Control logic of the lane retimer: enable handling, straps, register
   settings, rate detection, recovery circuit timing, lane routing,
   pattern generator and per-lane error checker.
   Assumes LINK_CLK_IN is the buffered input clock lane and may stop.
*/
`timescale 1ns/1ps
module trc_ctrl
   import trc_pkg::*;
#(
   parameter int CDR_ACQ_CYCLES = CDR_ACQ_CYC
) (
   input wire logic CLK_SYS_IN,
   input wire logic RESET_IN,
   input wire logic LINK_CLK_IN,
   input wire logic DEV_ENABLE_IN,
   input wire logic LANE_SWAP_POLARITY_PIN_IN,
   input wire logic EQUALIZER_SELECT_PIN_IN,
   input wire logic EQUALIZER_SELECT_FLOAT_IN,
   input wire logic SIGNAL_DETECT_ENABLE_IN,
   input wire logic TRANSMIT_TERMINATION_SELECT_IN,
   input wire logic TRANSMIT_TERMINATION_FLOAT_IN,
   input wire logic AUDIO_IN,
   input wire logic I2C_WR_IN,
   input wire logic I2C_LANE_SWAP_IN,
   input wire logic I2C_POL_SWAP_IN,
   input wire logic I2C_SIG_DET_IN,
   input wire logic I2C_AUDIO_DIS_IN,
   input wire logic [1:0] I2C_MODE_IN,
   input wire logic I2C_EQ_OVR_IN,
   input wire logic [4*EQ_W-1:0] I2C_EQ_GAIN_IN,
   input wire logic I2C_PRBS_EN_IN,
   input wire logic I2C_CHK_EN_IN,
   input wire logic ERR_CLR_IN,
   input wire logic INPUT_CLK_LANE_IN,
   input wire logic INPUT_DATA_LANE_TWO_IN,
   input wire logic INPUT_DATA_LANE_ONE_IN,
   input wire logic INPUT_DATA_LANE_ZERO_IN,
   output logic OUTPUT_CLK_LANE_OUT,
   output logic OUTPUT_DATA_LANE_TWO_OUT,
   output logic OUTPUT_DATA_LANE_ONE_OUT,
   output logic OUTPUT_DATA_LANE_ZERO_OUT,
   output logic LANE_OUT_OE_OUT,
   output logic DATA_TERM_EN_OUT,
   output logic TX_TERM_EN_OUT,
   output logic CDR_EN_OUT,
   output logic CDR_ACTIVE_OUT,
   output logic RETIMER_MODE_OUT,
   output logic STANDBY_OUT,
   output logic CLK_VALID_OUT,
   output logic [4*EQ_W-1:0] EQ_GAIN_OUT,
   output logic AUDIO_RETURN_OUTPUT_OUT,
   output logic [ERR_W-1:0] ERR_CNT_LANE_TWO_OUT,
   output logic [ERR_W-1:0] ERR_CNT_LANE_ONE_OUT,
   output logic [ERR_W-1:0] ERR_CNT_LANE_ZERO_OUT
);
   // ----------------------------------------------------------------
   // Functions
   // ----------------------------------------------------------------
   // Lane 3 is the clock lane; swap pairs 3 with 2 and 1 with 0.
   function automatic logic [1:0] src_lane(input logic [1:0] idx, input logic swap);
      src_lane = swap ? (idx ^ 2'h1) : idx;
   endfunction

   function automatic logic [1:0] tri_dec(input logic flt, input logic lvl);
      tri_dec = flt ? TRI_Z : (lvl ? TRI_HI : TRI_LO);
   endfunction

   // ----------------------------------------------------------------
   // Pin and toggle synchronisers
   // ----------------------------------------------------------------
   logic [7:0] pin_s;
   logic en_s, swpol_s, sig_s, aud_s, eqp_s, eqf_s, tp_s, tf_s;
   logic [3:0] tgl_s;
   logic div_q;
   logic [2:0] err_tgl_q;

   trc_sync #(.W(8)) u_pin_sync (
      .clk_in(CLK_SYS_IN),
      .d_in({DEV_ENABLE_IN, LANE_SWAP_POLARITY_PIN_IN, SIGNAL_DETECT_ENABLE_IN,
             AUDIO_IN, EQUALIZER_SELECT_PIN_IN, EQUALIZER_SELECT_FLOAT_IN,
             TRANSMIT_TERMINATION_SELECT_IN, TRANSMIT_TERMINATION_FLOAT_IN}),
      .q_out(pin_s)
   );
   assign {en_s, swpol_s, sig_s, aud_s, eqp_s, eqf_s, tp_s, tf_s} = pin_s;

   trc_sync #(.W(4)) u_tgl_sync (
      .clk_in(CLK_SYS_IN),
      .d_in({div_q, err_tgl_q}),
      .q_out(tgl_s)
   );

   // ----------------------------------------------------------------
   // Enable, straps and register settings
   // ----------------------------------------------------------------
   logic run_q, cfg_rst;
   logic strap_swap_q, strap_pol_q, strap_sig_q;
   logic [1:0] eq_mode_q, term_mode_q;
   logic i2c_swap_q, i2c_pol_q, i2c_sig_q, i2c_arc_dis_q;
   logic i2c_eq_ovr_q, i2c_prbs_q, i2c_chk_q;
   logic [1:0] i2c_mode_q;
   logic [4*EQ_W-1:0] i2c_eq_q;

   // A low enable acts as reset for everything software wrote.
   assign cfg_rst = RESET_IN | ~en_s;

   always_ff @(posedge CLK_SYS_IN) begin
      if (RESET_IN) begin
         run_q <= 1'b0;
      end else begin
         run_q <= en_s;
      end
   end

   // Straps are read once at each rise of the enable, when the supplies
   // are already stable by the system's own sequencing.
   always_ff @(posedge CLK_SYS_IN) begin
      if (RESET_IN) begin
         strap_swap_q <= 1'b0;
         strap_pol_q <= 1'b0;
         strap_sig_q <= 1'b0;
         eq_mode_q <= TRI_Z;
         term_mode_q <= TRI_Z;
      end else if (en_s && !run_q) begin
         strap_swap_q <= ~swpol_s;
         strap_pol_q <= swpol_s;
         strap_sig_q <= sig_s;
         eq_mode_q <= tri_dec(eqf_s, eqp_s);
         term_mode_q <= tri_dec(tf_s, tp_s);
      end
   end

   always_ff @(posedge CLK_SYS_IN) begin
      if (cfg_rst) begin
         i2c_swap_q <= 1'b0;
         i2c_pol_q <= 1'b0;
         i2c_sig_q <= 1'b0;
         i2c_arc_dis_q <= 1'b0;
         i2c_mode_q <= MODE_AUTO;
         i2c_eq_ovr_q <= 1'b0;
         i2c_eq_q <= '0;
         i2c_prbs_q <= 1'b0;
         i2c_chk_q <= 1'b0;
      end else if (I2C_WR_IN && run_q) begin
         i2c_swap_q <= I2C_LANE_SWAP_IN;
         i2c_pol_q <= I2C_POL_SWAP_IN;
         i2c_sig_q <= I2C_SIG_DET_IN;
         i2c_arc_dis_q <= I2C_AUDIO_DIS_IN;
         i2c_mode_q <= I2C_MODE_IN;
         i2c_eq_ovr_q <= I2C_EQ_OVR_IN;
         i2c_eq_q <= I2C_EQ_GAIN_IN;
         i2c_prbs_q <= I2C_PRBS_EN_IN;
         i2c_chk_q <= I2C_CHK_EN_IN;
      end
   end

   // ----------------------------------------------------------------
   // Rate detection
   // ----------------------------------------------------------------
   logic div_s_q;
   logic [7:0] win_q;
   logic [CNT_W-1:0] edge_q, rate_q;
   logic clk_valid, rate_1g, rate_2g;

   always_ff @(posedge CLK_SYS_IN) begin
      if (RESET_IN) begin
         div_s_q <= 1'b0;
         win_q <= '0;
         edge_q <= '0;
         rate_q <= '0;
      end else begin
         div_s_q <= tgl_s[3];
         win_q <= win_q + 8'h01;
         if (win_q == 8'(RATE_WIN - 1)) begin
            rate_q <= edge_q + CNT_W'(tgl_s[3] ^ div_s_q);
            edge_q <= '0;
         end else if (tgl_s[3] ^ div_s_q) begin
            edge_q <= edge_q + 10'h001;
         end
      end
   end

   assign clk_valid = rate_q >= CNT_VALID;
   assign rate_1g = rate_q >= CNT_1G;
   assign rate_2g = rate_q >= CNT_2G;

   // ----------------------------------------------------------------
   // Operating state
   // ----------------------------------------------------------------
   logic signal_detect_enable, standby, active, retimer_need, swap_act, pol_act_q;

   assign signal_detect_enable = strap_sig_q | i2c_sig_q;
   assign standby = run_q && signal_detect_enable && !clk_valid;
   assign active = run_q && !standby;
   assign retimer_need = active && (i2c_mode_q == MODE_RETIME ||
                         (i2c_mode_q[1] && rate_1g));
   assign swap_act = strap_swap_q | i2c_swap_q;

   always_ff @(posedge CLK_SYS_IN) begin
      if (RESET_IN) begin
         LANE_OUT_OE_OUT <= 1'b0;
         DATA_TERM_EN_OUT <= 1'b0;
         STANDBY_OUT <= 1'b0;
         CLK_VALID_OUT <= 1'b0;
         RETIMER_MODE_OUT <= 1'b0;
         pol_act_q <= 1'b0;
         TX_TERM_EN_OUT <= 1'b0;
         AUDIO_RETURN_OUTPUT_OUT <= 1'b0;
      end else begin
         LANE_OUT_OE_OUT <= active;
         DATA_TERM_EN_OUT <= active;
         STANDBY_OUT <= standby;
         CLK_VALID_OUT <= clk_valid;
         RETIMER_MODE_OUT <= retimer_need;
         pol_act_q <= (strap_pol_q | i2c_pol_q) && retimer_need;
         // The low strap is reserved and treated as no termination.
         TX_TERM_EN_OUT <= active && term_mode_q == TRI_Z && rate_2g;
         AUDIO_RETURN_OUTPUT_OUT <= run_q && !i2c_arc_dis_q && aud_s;
      end
   end

   // ----------------------------------------------------------------
   // Equalizer settings, indexed by physical input lane
   // ----------------------------------------------------------------
   logic [EQ_W-1:0] eq_base;

   always_comb begin
      case (eq_mode_q)
         TRI_HI: eq_base = EQ_10DB;
         TRI_LO: eq_base = EQ_7P5DB;
         default: begin
            if (rate_2g) begin
               eq_base = EQ_AD_HI;
            end else if (rate_1g) begin
               eq_base = EQ_AD_MID;
            end else begin
               eq_base = EQ_AD_LO;
            end
         end
      endcase
   end

   always_ff @(posedge CLK_SYS_IN) begin
      if (RESET_IN) begin
         EQ_GAIN_OUT <= '0;
      end else begin
         for (int p = 0; p < LANES; p++) begin
            // A physical lane takes the setting of the position it feeds.
            EQ_GAIN_OUT[p*EQ_W +: EQ_W] <= i2c_eq_ovr_q ?
               i2c_eq_q[src_lane(2'(p), swap_act)*EQ_W +: EQ_W] : eq_base;
         end
      end
   end

   // ----------------------------------------------------------------
   // Recovery circuit sequencing
   // ----------------------------------------------------------------
   trc_cdr_t cdr_q;
   logic [ACQ_W-1:0] acq_q;

   always_ff @(posedge CLK_SYS_IN) begin
      if (RESET_IN) begin
         cdr_q <= CDR_OFF;
         acq_q <= '0;
      end else begin
         acq_q <= '0;
         case (cdr_q)
            CDR_OFF: begin
               if (retimer_need) begin
                  cdr_q <= CDR_ACQ;
               end
            end
            CDR_ACQ: begin
               acq_q <= acq_q + 22'h000001;
               if (!retimer_need) begin
                  cdr_q <= CDR_OFF;
               end else if (acq_q == ACQ_W'(CDR_ACQ_CYCLES - 1)) begin
                  cdr_q <= CDR_ON;
               end
            end
            CDR_ON: begin
               if (!retimer_need) begin
                  cdr_q <= CDR_OFF;
               end
            end
            default: cdr_q <= CDR_OFF;
         endcase
      end
   end

   assign CDR_EN_OUT = cdr_q != CDR_OFF;
   assign CDR_ACTIVE_OUT = cdr_q == CDR_ON;

   // ----------------------------------------------------------------
   // Error counters
   // ----------------------------------------------------------------
   logic [2:0] err_s_q;
   logic [ERR_W-1:0] err_cnt_q [3];

   always_ff @(posedge CLK_SYS_IN) begin
      if (cfg_rst) begin
         err_s_q <= '0;
         for (int l = 0; l < 3; l++) err_cnt_q[l] <= '0;
      end else begin
         err_s_q <= tgl_s[2:0];
         for (int l = 0; l < 3; l++) begin
            if (ERR_CLR_IN) begin
               err_cnt_q[l] <= '0;
            end else if ((tgl_s[l] ^ err_s_q[l]) && err_cnt_q[l] != '1) begin
               err_cnt_q[l] <= err_cnt_q[l] + 16'h0001;
            end
         end
      end
   end

   assign ERR_CNT_LANE_TWO_OUT = err_cnt_q[2];
   assign ERR_CNT_LANE_ONE_OUT = err_cnt_q[1];
   assign ERR_CNT_LANE_ZERO_OUT = err_cnt_q[0];

   // ----------------------------------------------------------------
   // Link clock domain
   // ----------------------------------------------------------------
   logic [4:0] lnk_s;
   logic lrst, swap_l, pol_l, prbs_l, chk_l;
   logic [3:0] lane_q, out_d;
   logic [PRBS_W-1:0] prbs_q;
   logic [PRBS_W-1:0] hist_q [3];

   trc_sync #(.W(5)) u_lnk_sync (
      .clk_in(LINK_CLK_IN),
      .d_in({cfg_rst, swap_act, pol_act_q, i2c_prbs_q, i2c_chk_q}),
      .q_out(lnk_s)
   );
   assign {lrst, swap_l, pol_l, prbs_l, chk_l} = lnk_s;

   always_comb begin
      for (int k = 0; k < LANES; k++) begin
         out_d[k] = lane_q[src_lane(2'(k), swap_l)] ^ pol_l;
      end
      if (prbs_l) begin
         out_d[2:0] = prbs_q[2:0];
      end
   end

   always_ff @(posedge LINK_CLK_IN) begin
      if (lrst) begin
         lane_q <= '0;
         div_q <= 1'b0;
         prbs_q <= PRBS_SEED;
         {OUTPUT_CLK_LANE_OUT, OUTPUT_DATA_LANE_TWO_OUT} <= 2'h0;
         {OUTPUT_DATA_LANE_ONE_OUT, OUTPUT_DATA_LANE_ZERO_OUT} <= 2'h0;
      end else begin
         lane_q <= {INPUT_CLK_LANE_IN, INPUT_DATA_LANE_TWO_IN,
                    INPUT_DATA_LANE_ONE_IN, INPUT_DATA_LANE_ZERO_IN};
         div_q <= ~div_q;
         // The generator runs at the input clock rate.
         prbs_q <= {prbs_q[5:0], prbs_q[6] ^ prbs_q[5]};
         {OUTPUT_CLK_LANE_OUT, OUTPUT_DATA_LANE_TWO_OUT} <= out_d[3:2];
         {OUTPUT_DATA_LANE_ONE_OUT, OUTPUT_DATA_LANE_ZERO_OUT} <= out_d[1:0];
      end
   end

   // Self-synchronising check: the first seven bits after enabling may count.
   always_ff @(posedge LINK_CLK_IN) begin
      if (lrst) begin
         err_tgl_q <= '0;
         for (int l = 0; l < 3; l++) hist_q[l] <= '0;
      end else begin
         for (int l = 0; l < 3; l++) begin
            hist_q[l] <= {hist_q[l][5:0], out_d[l]};
            if (chk_l && (out_d[l] ^ hist_q[l][6] ^ hist_q[l][5])) begin
               err_tgl_q[l] <= ~err_tgl_q[l];
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   property p_off_hiz;
      @(posedge CLK_SYS_IN) disable iff (RESET_IN)
      !run_q |=> !LANE_OUT_OE_OUT && !DATA_TERM_EN_OUT && !CDR_EN_OUT;
   endproperty
   a_off_hiz: assert property (p_off_hiz) else $error("lanes driven while disabled");

   property p_cfg_clear;
      @(posedge CLK_SYS_IN) disable iff (RESET_IN)
      !en_s |=> i2c_mode_q == MODE_AUTO && !i2c_prbs_q && !i2c_arc_dis_q;
   endproperty
   a_cfg_clear: assert property (p_cfg_clear) else $error("settings kept");

   property p_cdr_on;
      @(posedge CLK_SYS_IN) disable iff (RESET_IN)
      cdr_q == CDR_ACQ |-> acq_q < ACQ_W'(CDR_MAX_CYC);
   endproperty
   a_cdr_on: assert property (p_cdr_on) else $error("recovery too slow");

   property p_cdr_off;
      @(posedge CLK_SYS_IN) disable iff (RESET_IN)
      !retimer_need |=> !CDR_EN_OUT;
   endproperty
   a_cdr_off: assert property (p_cdr_off) else $error("recovery not off");

   property p_route;
      @(posedge LINK_CLK_IN) disable iff (lrst)
      swap_l && !pol_l && !prbs_l |=> OUTPUT_CLK_LANE_OUT == $past(lane_q[2]);
   endproperty
   a_route: assert property (p_route) else $error("swap routing wrong");

   property p_pol;
      @(posedge CLK_SYS_IN) disable iff (RESET_IN)
      pol_act_q |-> RETIMER_MODE_OUT;
   endproperty
   a_pol: assert property (p_pol) else $error("inversion outside retimer");

   property p_eq_hi;
      @(posedge CLK_SYS_IN) disable iff (RESET_IN)
      eq_mode_q == TRI_HI && !i2c_eq_ovr_q |=> EQ_GAIN_OUT == {4{EQ_10DB}};
   endproperty
   a_eq_hi: assert property (p_eq_hi) else $error("fixed gain wrong");

   property p_standby;
      @(posedge CLK_SYS_IN) disable iff (RESET_IN)
      STANDBY_OUT |-> !LANE_OUT_OE_OUT && !DATA_TERM_EN_OUT && !CDR_EN_OUT;
   endproperty
   a_standby: assert property (p_standby) else $error("standby not quiet");

   property p_term;
      @(posedge CLK_SYS_IN) disable iff (RESET_IN)
      term_mode_q != TRI_Z || !rate_2g |=> !TX_TERM_EN_OUT;
   endproperty
   a_term: assert property (p_term) else $error("termination wrong");

   property p_err;
      @(posedge CLK_SYS_IN) disable iff (cfg_rst)
      !ERR_CLR_IN |=> ERR_CNT_LANE_ZERO_OUT >= $past(ERR_CNT_LANE_ZERO_OUT);
   endproperty
   a_err: assert property (p_err) else $error("error count fell");

   c_cdr_on: cover property (@(posedge CLK_SYS_IN) disable iff (RESET_IN)
      $rose(CDR_ACTIVE_OUT));
   c_standby: cover property (@(posedge CLK_SYS_IN) disable iff (RESET_IN)
      $rose(STANDBY_OUT));
   c_swap: cover property (@(posedge LINK_CLK_IN) disable iff (lrst) swap_l && !prbs_l);
   c_err: cover property (@(posedge CLK_SYS_IN) disable iff (RESET_IN)
      ERR_CNT_LANE_ONE_OUT != '0);
endmodule // trc_ctrl

// >>> dv/trc_src_model.sv
/*
   Behavioural source model: link clock and the four input lanes.
   Assumes lanes_in is ordered clock, data2, data1, data0 from the top bit.
*/
`timescale 1ns/1ps
module trc_src_model (
   input wire logic run_in,
   input wire logic [3:0] lanes_in,
   output logic link_clk_out,
   output logic [3:0] lanes_out
);
   // ----------------------------------------
   // Clock and lanes
   // ----------------------------------------
   // The clock stands low between frames and the lanes then keep changing,
   // so that stale data can never look valid to the design.
   initial begin
      link_clk_out = 1'b0;
      lanes_out = 4'h5;
      #1.3;
      forever begin
         #6;
         if (run_in) begin
            link_clk_out = ~link_clk_out;
            if (!link_clk_out) lanes_out = lanes_in;
         end else begin
            link_clk_out = 1'b0;
            lanes_out = ~lanes_out;
         end
      end
   end
endmodule // trc_src_model

// >>> dv/testbench.sv
/*
   Self-checking bench for the retimer control block.
   Assumes the source model supplies the link clock and the lane levels.
*/
`timescale 1ns/1ps
module testbench;
   import trc_pkg::*;
   logic clk = 0, rst = 1, en = 0, swp = 0, eqp = 1, eqf = 0, sde = 0, tflt = 0, aud, run = 0;
   logic wr = 0, ls = 0, pl = 0, ad = 0, ov = 0;
   logic [1:0] md = 2'h2;
   logic [19:0] gn, eqg;
   logic [3:0] ln = 4'h0, li, lo;
   logic lk, oe, dt, tt, cen, cact, rm, sb, arc, cv;
   logic sd = 0, pe = 0, ce = 0, ecl = 0;
   logic [15:0] e2, e1, e0;
   // Enable low time before each rise: 100 us at the system clock rate.
   localparam int EN_LOW_CYC = 100 * CLK_MHZ;
   int fails = 0, checks_done = 0;
   always #2 clk = ~clk;
   trc_src_model i_trc_src_model (.run_in(run), .lanes_in(ln), .link_clk_out(lk), .lanes_out(li));
   trc_ctrl #(.CDR_ACQ_CYCLES(20)) i_trc_ctrl (.CLK_SYS_IN(clk), .RESET_IN(rst), .LINK_CLK_IN(lk),
      .DEV_ENABLE_IN(en), .LANE_SWAP_POLARITY_PIN_IN(swp), .EQUALIZER_SELECT_PIN_IN(eqp),
      .EQUALIZER_SELECT_FLOAT_IN(eqf), .SIGNAL_DETECT_ENABLE_IN(sde),
      .TRANSMIT_TERMINATION_SELECT_IN(1'b0), .TRANSMIT_TERMINATION_FLOAT_IN(tflt),
      .AUDIO_IN(aud), .I2C_WR_IN(wr), .I2C_LANE_SWAP_IN(ls), .I2C_POL_SWAP_IN(pl),
      .I2C_SIG_DET_IN(sd), .I2C_AUDIO_DIS_IN(ad), .I2C_MODE_IN(md), .I2C_EQ_OVR_IN(ov),
      .I2C_EQ_GAIN_IN(gn), .I2C_PRBS_EN_IN(pe), .I2C_CHK_EN_IN(ce), .ERR_CLR_IN(ecl),
      .INPUT_CLK_LANE_IN(li[3]), .INPUT_DATA_LANE_TWO_IN(li[2]),
      .INPUT_DATA_LANE_ONE_IN(li[1]), .INPUT_DATA_LANE_ZERO_IN(li[0]),
      .OUTPUT_CLK_LANE_OUT(lo[3]), .OUTPUT_DATA_LANE_TWO_OUT(lo[2]),
      .OUTPUT_DATA_LANE_ONE_OUT(lo[1]), .OUTPUT_DATA_LANE_ZERO_OUT(lo[0]),
      .LANE_OUT_OE_OUT(oe), .DATA_TERM_EN_OUT(dt), .TX_TERM_EN_OUT(tt), .CDR_EN_OUT(cen),
      .CDR_ACTIVE_OUT(cact), .RETIMER_MODE_OUT(rm), .STANDBY_OUT(sb), .CLK_VALID_OUT(cv),
      .EQ_GAIN_OUT(eqg), .AUDIO_RETURN_OUTPUT_OUT(arc), .ERR_CNT_LANE_TWO_OUT(e2),
      .ERR_CNT_LANE_ONE_OUT(e1), .ERR_CNT_LANE_ZERO_OUT(e0));
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic chk(input string nm, input logic [19:0] e, input logic [19:0] s);
      checks_done++;
      if (s !== e) begin
         fails++;
         $display("BAD %s exp %h got %h", nm, e, s);
      end
   endtask
   task automatic close_out();
      if (fails == 0 && checks_done > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic wr_cfg(input logic [1:0] m, input logic s, p, a, o);
      {md, ls, pl, ad, ov} = {m, s, p, a, o};
      wr = 1;
      cyc(1);
      wr = 0;
      cyc(6);
   endtask
   // The low time also stands for the wait after the supplies settle.
   task automatic power(input logic s, p);
      en = 0;
      {swp, eqp} = {s, p};
      cyc(EN_LOW_CYC);
      en = 1;
      cyc(1200);
   endtask
   // With the write, 30 cycles in all, i.e. 120 ns.
   task automatic cdr_wait(input logic w);
      int k;
      k = 0;
      while ((w ? cact : cen) !== w && k < 23) begin
         cyc(1);
         k++;
      end
      if ((w ? cact : cen) !== w) begin
         chk("cdr", w, !w);
         close_out();
      end
   endtask
   function automatic logic [3:0] route(input logic [3:0] i, input logic sw, iv);
      route = sw ? {i[2], i[3], i[0], i[1]} : i;
      if (iv) route = ~route;
   endfunction
   // ----------------------------------------
   // Sequence
   // ----------------------------------------
   initial begin
      void'($urandom(32'h37b1));
      aud = $urandom;
      gn = $urandom;
      cyc(4);
      rst = 0;
      cyc(2);
      chk("oe", 0, oe);
      wr_cfg(MODE_AUTO, 0, 0, 1, 0);
      run = 1;
      power(0, 1);
      chk("arc", aud, arc);
      chk("eq", {4{EQ_10DB}}, eqg);
      chk("sb", 0, sb);
      chk("cv", 1, cv);
      for (int i = 0; i < 4; i++) begin
         ln = $urandom;
         cyc(20);
         chk("lane", route(ln, 1, 0), lo);
      end
      chk("rm", 0, rm);
      wr_cfg(MODE_AUTO, 0, 0, 0, 1);
      chk("eq", {gn[14:10], gn[19:15], gn[4:0], gn[9:5]}, eqg);
      wr_cfg(MODE_RETIME, 0, 0, 1, 0);
      cdr_wait(1);
      chk("lane", route(ln, 1, 0), lo);
      chk("arc", 0, arc);
      wr_cfg(MODE_REDRV, 0, 0, 1, 0);
      cdr_wait(0);
      power(1, 0);
      chk("arc", aud, arc);
      chk("eq", {4{EQ_7P5DB}}, eqg);
      wr_cfg(MODE_RETIME, 1, 0, 0, 0);
      ln = $urandom;
      cyc(20);
      chk("lane", route(ln, 1, 1), lo);
      wr_cfg(MODE_AUTO, 0, 0, 0, 0);
      cyc(20);
      chk("lane", route(ln, 0, 0), lo);
      // A clean generated pattern gives no errors once the warm-up count is cleared.
      {pe, ce} = 2'h3;
      wr_cfg(MODE_AUTO, 0, 0, 0, 0);
      cyc(100);
      ecl = 1;
      cyc(1);
      ecl = 0;
      cyc(100);
      chk("err2", 0, e2);
      chk("err1", 0, e1);
      chk("err0", 0, e0);
      // Steady ones on every data lane break the pattern on each bit.
      {pe, ln} = 5'h0f;
      wr_cfg(MODE_AUTO, 0, 0, 0, 0);
      cyc(100);
      chk("err2", 1, e2 != 16'h0000);
      chk("err1", 1, e1 != 16'h0000);
      chk("err0", 1, e0 != 16'h0000);
      sd = 1;
      wr_cfg(MODE_AUTO, 0, 0, 0, 0);
      run = 0;
      cyc(600);
      chk("sb", 1, sb);
      {sde, tflt, eqf} = 3'h7;
      power(1, 0);
      chk("sb", 1, sb);
      chk("cv", 0, cv);
      chk("oe", 0, oe);
      chk("dt", 0, dt);
      chk("cen", 0, cen);
      run = 1;
      cyc(1200);
      chk("sb", 0, sb);
      chk("dt", 1, dt);
      chk("oe", 1, oe);
      chk("eq", {4{EQ_AD_LO}}, eqg);
      chk("tt", 0, tt);
      close_out();
   end
endmodule // testbench
